//--- rtl/cmdu_consts.vh
// Constants for the cascadable multiply/divide unit
`ifndef CMDU_CONSTS_VH
`define CMDU_CONSTS_VH

// Register select codes
`define CMDU_SEL_X        2'h0
`define CMDU_SEL_Z        2'h1
`define CMDU_SEL_Y        2'h2
`define CMDU_SEL_CS       2'h3

// Control byte fields
`define CMDU_CTL_OP_LO    0
`define CMDU_CTL_OP_HI    1
`define CMDU_CTL_CLR_Z    2
`define CMDU_CTL_CLR_Y    3
`define CMDU_CTL_UNITS_LO 4
`define CMDU_CTL_UNITS_HI 5
`define CMDU_CTL_SEQ_RST  6
`define CMDU_CTL_PRESC    7

// Operation codes in control bits 1:0
`define CMDU_OP_NONE      2'h0
`define CMDU_OP_MUL       2'h1
`define CMDU_OP_DIV       2'h2

// Status byte
`define CMDU_STAT_OVF     0
`define CMDU_STAT_ZERO    7'h00

// Reset values
`define CMDU_CTRL_RST     8'h00
`define CMDU_WORD_RST     32'h00000000
`define CMDU_BYTE_RST     8'h00
`define CMDU_STEPS_RST    6'h00
`define CMDU_PRESC_RST    3'h0

// Sequence counter value that selects the most significant slice
`define CMDU_SEQ_MSU      2'h3

// Prescaler terminal counts (divide by 1, 2, 4, 8)
`define CMDU_PRESC_DIV1   3'h0
`define CMDU_PRESC_DIV2   3'h1
`define CMDU_PRESC_DIV4   3'h3
`define CMDU_PRESC_DIV8   3'h7

// Operand width masks per unit count
`define CMDU_MASK_1       32'h000000ff
`define CMDU_MASK_2       32'h0000ffff
`define CMDU_MASK_3       32'h00ffffff
`define CMDU_MASK_4       32'hffffffff

`endif

//--- rtl/cmdu_muldiv_unit.v
// Cascade of one to four multiply/divide slices behind an 8-bit port
`timescale 1ns/10ps
`include "cmdu_consts.vh"

// Overview of operation
// - Divide 16N-bit dividend by 8N-bit divisor
// - Multiply two 8N-bit operands into 16N bits
// - One to four slices, 8 bits each
// - Operation ends after 8N plus one pulses
// - Only a control write starts an operation
// - Overflow when upper dividend not below divisor
// - Select lines and strobes pick the access
// - Bytes go most to least significant slice
// - Slice answers when counter matches its position
// - Clear or control bit 6 resets counters
// - Control bit 7 enables the prescaler
// - Prescale by 2, 4 or 8 per count
// - Clear resets counters and shift generator
// - Four slices wrap; fewer need counter reset
// - Divide leaves X, quotient Z, remainder Y
// - Overflow on carry/overflow pin and status
// - Control bit 2 clears Z
// - Multiply X by Z into Y:Z
// - Multiply adds old Y; bit 3 clears Y
// - Carry/overflow pin low on overflow
// - Status bit 0 overflow, others zero
module cmdu_muldiv_unit (
  // Clock, reset, enable
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       ce_in,
  // Clear pin, active low
  input  wire       clear_n_in,
  // Register port
  input  wire       chip_enable_in,
  input  wire [1:0] register_select_lines_in,
  input  wire       wr_strobe_in,
  input  wire       rd_strobe_in,
  input  wire [7:0] wdata_in,
  output reg  [7:0] rdata_out,
  // Carry-out/overflow pin of the most significant slice
  output wire       carry_ovf_n_out,
  output wire       carry_ovf_oe_out,
  // Engine state
  output wire       busy_out,
  output reg        shift_pulse_out
);

  // Operand and result words
  reg  [31:0] x_word;
  reg  [31:0] y_word;
  reg  [31:0] z_word;
  reg  [7:0]  ctrl;
  reg         ovf;
  // Per-register sequence counters
  reg  [1:0]  seq_x;
  reg  [1:0]  seq_y;
  reg  [1:0]  seq_z;
  // Shift pulse generator
  reg         busy;
  reg  [5:0]  steps;
  reg  [2:0]  presc_cnt;
  // Clear synchroniser
  reg         clear_n_meta;
  reg         clear_n_sync;

  wire [2:0]  units;
  wire [31:0] mask;
  wire [31:0] msb;
  wire [2:0]  presc_last;
  wire        tick;
  wire [1:0]  op;
  wire        wr_ok;
  wire        rd_ok;
  wire [2:0]  hit_x;
  wire [2:0]  hit_y;
  wire [2:0]  hit_z;
  wire [1:0]  new_units_f;
  wire [31:0] new_y;
  wire [32:0] msum;
  wire [31:0] mul_y;
  wire [31:0] mul_z;
  wire [32:0] dsh;
  wire        dge;
  wire [32:0] ddiff;
  wire [31:0] div_y;
  wire [31:0] div_z;
  wire [31:0] xm;
  wire [31:0] ym;
  wire [31:0] zm;
  wire [31:0] new_mask;

  // one to four slices
  // Unit count from the two-bit field: 0 means one slice
  function [2:0] unit_count;
    input [1:0] f;
    begin
      unit_count = {1'b0, f} + 3'h1;
    end
  endfunction

  function [31:0] width_mask;
    input [2:0] n;
    begin
      case (n)
        3'h1:    width_mask = `CMDU_MASK_1;
        3'h2:    width_mask = `CMDU_MASK_2;
        3'h3:    width_mask = `CMDU_MASK_3;
        default: width_mask = `CMDU_MASK_4;
      endcase
    end
  endfunction

  // Total shift pulses, 8N + 1
  function [5:0] step_total;
    input [2:0] n;
    begin
      step_total = {n, 3'h0} + 6'h1;
    end
  endfunction

  // Slice lookup: bit 2 says a slice sits at this position,
  // bits 1:0 give its byte lane within the word
  function [2:0] slice_hit;
    input [1:0] pos;
    input [2:0] n;
    begin
      slice_hit = {1'b0, pos} + n;
    end
  endfunction

  function [7:0] get_byte;
    input [31:0] w;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    get_byte = w[7:0];
        2'h1:    get_byte = w[15:8];
        2'h2:    get_byte = w[23:16];
        default: get_byte = w[31:24];
      endcase
    end
  endfunction

  function [31:0] put_byte;
    input [31:0] w;
    input [1:0]  idx;
    input [7:0]  b;
    begin
      case (idx)
        2'h0:    put_byte = {w[31:8], b};
        2'h1:    put_byte = {w[31:16], b, w[7:0]};
        2'h2:    put_byte = {w[31:24], b, w[15:0]};
        default: put_byte = {b, w[23:0]};
      endcase
    end
  endfunction

  // Byte read through a sequence counter, zero when no slice
  function [7:0] read_lane;
    input [31:0] w;
    input [2:0]  hit;
    begin
      if (hit[2]) begin
        read_lane = get_byte(w, hit[1:0]);
      end else begin
        read_lane = `CMDU_BYTE_RST;
      end
    end
  endfunction

  assign units = unit_count(ctrl[`CMDU_CTL_UNITS_HI:`CMDU_CTL_UNITS_LO]);
  assign mask  = width_mask(units);
  assign msb   = mask & ~(mask >> 1);
  assign op    = ctrl[`CMDU_CTL_OP_HI:`CMDU_CTL_OP_LO];

  // engine works on the active lanes only; a wider earlier
  // setup may have left stale bytes above them
  assign xm    = x_word & mask;
  assign ym    = y_word & mask;
  assign zm    = z_word & mask;

  assign presc_last = !ctrl[`CMDU_CTL_PRESC] ? `CMDU_PRESC_DIV1 :
                      (units == 3'h1)        ? `CMDU_PRESC_DIV2 :
                      (units == 3'h2)        ? `CMDU_PRESC_DIV4 :
                                               `CMDU_PRESC_DIV8;
  // Tick only while an operation runs
  assign tick = busy && (presc_cnt == presc_last);

  // access decode, engine owns the words while busy
  // Accesses during clear are dropped
  assign wr_ok = chip_enable_in && wr_strobe_in && !busy && clear_n_sync;
  assign rd_ok = chip_enable_in && rd_strobe_in && clear_n_sync;

  assign hit_x = slice_hit(seq_x, units);
  assign hit_y = slice_hit(seq_y, units);
  assign hit_z = slice_hit(seq_z, units);

  // Values a control write would take effect with
  assign new_units_f = wdata_in[`CMDU_CTL_UNITS_HI:`CMDU_CTL_UNITS_LO];
  assign new_mask    = width_mask(unit_count(new_units_f));
  assign new_y = wdata_in[`CMDU_CTL_CLR_Y] ? `CMDU_WORD_RST : y_word;

  // conditional add of X onto Y, shift Y:Z right
  // msum[8N] is the carry that drops into Y's top lane (msum[32] with four slices)
  assign msum  = {1'b0, ym} + (zm[0] ? {1'b0, xm} : 33'h0);
  assign mul_y = msum[32:1];
  assign mul_z = (zm >> 1) | (msum[0] ? msb : `CMDU_WORD_RST);

  // shift Y:Z left, conditional subtract of X
  // The bit leaving Y's top lane stays in dsh, so a partial
  // remainder near full range still compares right against X
  assign dsh   = {ym, |(zm & msb)};
  assign dge   = dsh >= {1'b0, xm};
  assign ddiff = dsh - {1'b0, xm};
  assign div_y = (dge ? ddiff[31:0] : dsh[31:0]) & mask;
  assign div_z = ((zm << 1) & mask) | {31'h0, dge};

  assign carry_ovf_n_out  = ~ovf;
  // Output enable tracks chip enable like a three-state driver
  assign carry_ovf_oe_out = chip_enable_in;
  assign busy_out         = busy;

  // Clear pin synchroniser
  // Resets low: block stays cleared two edges past reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clear_n_meta <= 1'b0;
      clear_n_sync <= 1'b0;
    end else if (ce_in) begin
      clear_n_meta <= clear_n_in;
      clear_n_sync <= clear_n_meta;
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= `CMDU_BYTE_RST;
    end else if (ce_in) begin
      rdata_out <= `CMDU_BYTE_RST;
      if (rd_ok) begin
        case (register_select_lines_in)
          `CMDU_SEL_X: rdata_out <= read_lane(x_word, hit_x);
          `CMDU_SEL_Z: rdata_out <= read_lane(z_word, hit_z);
          `CMDU_SEL_Y: rdata_out <= read_lane(y_word, hit_y);
          default:     rdata_out <= {`CMDU_STAT_ZERO, ovf};
        endcase
      end
    end
  end

  // Registers, sequence counters and shift engine
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      x_word          <= `CMDU_WORD_RST;
      y_word          <= `CMDU_WORD_RST;
      z_word          <= `CMDU_WORD_RST;
      ctrl            <= `CMDU_CTRL_RST;
      ovf             <= 1'b0;
      seq_x           <= `CMDU_SEQ_MSU;
      seq_y           <= `CMDU_SEQ_MSU;
      seq_z           <= `CMDU_SEQ_MSU;
      busy            <= 1'b0;
      steps           <= `CMDU_STEPS_RST;
      presc_cnt       <= `CMDU_PRESC_RST;
      shift_pulse_out <= 1'b0;
    end else if (ce_in) begin
      // Pulse output trails the engine tick by one cycle
      shift_pulse_out <= tick;
      if (!clear_n_sync) begin
        // clear resets counters and shift generator
        seq_x      <= `CMDU_SEQ_MSU;
        seq_y      <= `CMDU_SEQ_MSU;
        seq_z      <= `CMDU_SEQ_MSU;
        busy       <= 1'b0;
        steps      <= `CMDU_STEPS_RST;
        presc_cnt  <= `CMDU_PRESC_RST;
        ctrl[`CMDU_CTL_OP_HI:`CMDU_CTL_OP_LO] <= `CMDU_OP_NONE;
      end else if (busy) begin
        if (tick) begin
          presc_cnt <= `CMDU_PRESC_RST;
          // 8N + 1 pulses, first one only sets up
          steps <= steps - 6'h1;
          if (steps == 6'h1) begin
            busy <= 1'b0;
          end
          // X never written by the engine
          if (steps != step_total(units)) begin
            if (op == `CMDU_OP_MUL) begin
              y_word <= mul_y;
              z_word <= mul_z;
            end else begin
              y_word <= div_y;
              z_word <= div_z;
            end
          end
        end else begin
          presc_cnt <= presc_cnt + 3'h1;
        end
      end else if (rd_ok) begin
        // reads walk down the slices and wrap
        case (register_select_lines_in)
          `CMDU_SEL_X: seq_x <= seq_x - 2'h1;
          `CMDU_SEL_Z: seq_z <= seq_z - 2'h1;
          `CMDU_SEL_Y: seq_y <= seq_y - 2'h1;
          default:     seq_x <= seq_x;
        endcase
      end else if (wr_ok) begin
        case (register_select_lines_in)
          `CMDU_SEL_X: begin
            if (hit_x[2]) begin
              x_word <= put_byte(x_word, hit_x[1:0], wdata_in);
            end
            // Counter runs 3, 2, 1, 0 then wraps to 3
            seq_x <= seq_x - 2'h1;
          end
          `CMDU_SEL_Z: begin
            if (hit_z[2]) begin
              z_word <= put_byte(z_word, hit_z[1:0], wdata_in);
            end
            seq_z <= seq_z - 2'h1;
          end
          `CMDU_SEL_Y: begin
            if (hit_y[2]) begin
              y_word <= put_byte(y_word, hit_y[1:0], wdata_in);
            end
            seq_y <= seq_y - 2'h1;
          end
          default: begin
            // Clears below land before the engine's first step
            ctrl <= wdata_in;
            if (wdata_in[`CMDU_CTL_SEQ_RST]) begin
              seq_x <= `CMDU_SEQ_MSU;
              seq_y <= `CMDU_SEQ_MSU;
              seq_z <= `CMDU_SEQ_MSU;
            end
            if (wdata_in[`CMDU_CTL_CLR_Z]) begin
              z_word <= `CMDU_WORD_RST;
            end
            if (wdata_in[`CMDU_CTL_CLR_Y]) begin
              y_word <= `CMDU_WORD_RST;
            end
            // overflow latched on every control load
            // A zero divisor flags overflow too; results are junk then
            ovf <= (wdata_in[`CMDU_CTL_OP_HI:`CMDU_CTL_OP_LO] ==
                    `CMDU_OP_DIV) &&
                   ((new_y & new_mask) >= (x_word & new_mask));
            // start only from a control write
            if ((wdata_in[`CMDU_CTL_OP_HI:`CMDU_CTL_OP_LO] ==
                 `CMDU_OP_MUL) ||
                (wdata_in[`CMDU_CTL_OP_HI:`CMDU_CTL_OP_LO] ==
                 `CMDU_OP_DIV)) begin
              busy      <= 1'b1;
              steps     <= step_total(unit_count(new_units_f));
              presc_cnt <= `CMDU_PRESC_RST;
            end
          end
        endcase
      end
    end
  end

endmodule

//--- tb/cmdu_host.sv
// Host bus model driving the register port
`timescale 1ns/10ps
module cmdu_host (
  // Clock
  input  logic       clk_in,
  // Register port
  output logic [1:0] sel_out,
  output logic       wr_out,
  output logic       rd_out,
  output logic [7:0] wd_out,
  input  logic [7:0] rdata_in
);
  initial begin
    sel_out = 2'h0;
    wr_out  = 1'b0;
    rd_out  = 1'b0;
    wd_out  = 8'h00;
  end
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_in);
    sel_out <= s;
    wd_out  <= d;
    wr_out  <= 1'b1;
    @(posedge clk_in);
    wr_out  <= 1'b0;
    wd_out  <= ~d;
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk_in);
    sel_out <= s;
    rd_out  <= 1'b1;
    @(posedge clk_in);
    rd_out  <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule

//--- tb/cmdu_muldiv_sva.sv
// Assertion checker for the multiply/divide unit
`timescale 1ns/10ps
module cmdu_muldiv_sva (
  // Clock, reset, enable
  input logic       clk_in,
  input logic       resetn_in,
  input logic       ce_in,
  // Register port
  input logic       chip_enable_in,
  input logic [1:0] register_select_lines_in,
  input logic       wr_strobe_in,
  input logic       rd_strobe_in,
  input logic [7:0] wdata_in,
  input logic [7:0] rdata_out,
  // Outputs
  input logic       carry_ovf_n_out,
  input logic       carry_ovf_oe_out,
  input logic       busy_out,
  input logic       shift_pulse_out
);
  logic [9:0] cnt;
  logic [9:0] len;
  logic [1:0] u;
  logic       wc;
  logic       go;
  assign u  = wdata_in[5:4];
  assign wc = wr_strobe_in && ce_in && chip_enable_in
              && register_select_lines_in == 2'h3;
  assign go = wc && !busy_out
              && (wdata_in[1:0] == 2'h1 || wdata_in[1:0] == 2'h2);
  // Expected busy length S*(8N+1)
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= 10'h000;
      len <= 10'h000;
    end else begin
      cnt <= busy_out ? cnt + 10'h001 : 10'h000;
      if (go)
        len <= (wdata_in[7] ? 10'h001 << (u == 2'h3 ? 2'h3 : u + 2'h1)
                : 10'h001) * ({5'h00, u, 3'h0} + 10'h009);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_LEN: assert property ($fell(busy_out) |-> cnt == len)
    else $error("operation length wrong");
  AST_START: assert property (go |=> busy_out)
    else $error("control write did not start");
  AST_NOSTART: assert property ($rose(busy_out) |-> $past(wc))
    else $error("operation began without control write");
  AST_RD0: assert property (!(rd_strobe_in && chip_enable_in)
    |=> rdata_out == 8'h00) else $error("read data without read");
  AST_STAT: assert property (rd_strobe_in && wc == 1'b0
    && chip_enable_in && register_select_lines_in == 2'h3
    |=> rdata_out == {7'h00, !carry_ovf_n_out})
    else $error("status byte wrong");
  AST_OE: assert property (carry_ovf_oe_out == chip_enable_in)
    else $error("overflow pin enable wrong");
  AST_OVF: assert property (wc && !busy_out
    && wdata_in[1:0] != 2'h2 |=> carry_ovf_n_out)
    else $error("overflow without divide");
  AST_HOLD: assert property (busy_out && $past(busy_out)
    |-> $stable(carry_ovf_n_out)) else $error("overflow moved");
  AST_SHIFT: assert property (shift_pulse_out |-> $past(busy_out))
    else $error("shift pulse while idle");
  cover property (go && wdata_in[1:0] == 2'h2);
  cover property (go && wdata_in[7]);
  cover property ($fell(busy_out) && !carry_ovf_n_out);
endmodule

bind cmdu_muldiv_unit cmdu_muldiv_sva u_sva (.clk_in, .resetn_in, .ce_in,
  .chip_enable_in, .register_select_lines_in, .wr_strobe_in,
  .rd_strobe_in, .wdata_in, .rdata_out, .carry_ovf_n_out,
  .carry_ovf_oe_out, .busy_out, .shift_pulse_out);

//--- tb/cmdu_muldiv_unit_tb_top.sv
// Self-checking bench for the multiply/divide unit
`timescale 1ns/10ps
module cmdu_muldiv_unit_tb_top;
  logic       clk_in;
  logic       resetn_in;
  logic       clear_n_in;
  logic       chip_enable_in;
  logic [1:0] sel;
  logic       wr;
  logic       rd;
  logic [7:0] wd;
  logic [7:0] rdata;
  logic       ovf_n;
  logic       ovf_oe;
  logic       busy;
  logic       ce;
  integer     error_cnt = 0;
  integer     cmp_count = 0;

  cmdu_muldiv_unit u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .ce_in(ce), .clear_n_in(clear_n_in),
    .chip_enable_in(chip_enable_in), .register_select_lines_in(sel),
    .wr_strobe_in(wr), .rd_strobe_in(rd), .wdata_in(wd),
    .rdata_out(rdata), .carry_ovf_n_out(ovf_n),
    .carry_ovf_oe_out(ovf_oe), .busy_out(busy), .shift_pulse_out());
  cmdu_host u_host (.clk_in(clk_in), .sel_out(sel), .wr_out(wr),
    .rd_out(rd), .wd_out(wd), .rdata_in(rdata));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [31:0] g,
                     input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic put(input logic [1:0] s, input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      u_host.wr(s, v[8*i+:8]);
  endtask

  task automatic get(input logic [1:0] s, output logic [31:0] v,
                     input int n);
    logic [7:0] b;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      u_host.rd(s, b);
      v = {v[23:0], b};
    end
  endtask

  // Clear pin, empty slots, four-slice wrap, pin enable
  task automatic t_seq;
    logic [31:0] g;
    u_host.wr(2'h3, 8'h50);
    u_host.wr(2'h0, 8'haa);
    @(posedge clk_in);
    clear_n_in     <= 1'b0;
    chip_enable_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1 chk("oe", ovf_oe, 0);
    @(posedge clk_in);
    clear_n_in     <= 1'b1;
    chip_enable_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    put(2'h0, 32'h1234, 2);
    u_host.wr(2'h0, 8'hff);
    u_host.wr(2'h3, 8'h50);
    get(2'h0, g, 2);
    chk("clear", g, 32'h1234);
    u_host.wr(2'h3, 8'h70);
    put(2'h0, 32'h01020304, 4);
    put(2'h0, 32'hcafe1234, 4);
    get(2'h0, g, 4);
    chk("wrap", g, 32'hcafe1234);
    @(posedge clk_in);
    ce <= 1'b0;
    u_host.wr(2'h0, 8'h5a);
    ce <= 1'b1;
    get(2'h0, g, 4);
    chk("ce", g, 32'hcafe1234);
    $display("seq done");
  endtask

  // One operation: cfg is prescaler, clear Y, clear Z
  task automatic run_op(input int n, input logic [1:0] op,
    input logic [2:0] cfg, input logic [31:0] x, input logic [31:0] y,
    input logic [31:0] z);
    logic [63:0] e;
    logic [31:0] gx;
    logic [31:0] gy;
    logic [31:0] gz;
    logic [31:0] m;
    logic [7:0]  st;
    logic [1:0]  u;
    logic        ov;
    u = 2'(n - 1);
    m = 32'hffffffff >> (32 - 8 * n);
    u_host.wr(2'h3, {2'b01, u, 4'h0});
    put(2'h0, x, n);
    put(2'h2, y, n);
    put(2'h1, z, n);
    #1 chk("idle", busy, 0);
    u_host.wr(2'h3, {cfg[2], 1'b1, u, cfg[1:0], op});
    #1 chk("start", busy, 1);
    for (int k = 0; k < 400 && busy === 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    chk("done", busy, 0);
    if (cfg[1])
      y = 32'h0;
    if (cfg[0])
      z = 32'h0;
    ov = op == 2'h2 && y >= x;
    e = ({32'h0, y} << (8 * n)) | z;
    if (op == 2'h1)
      e = x * z + y;
    else
      e = ((e % x) << (8 * n)) | (e / x);
    get(2'h2, gy, n);
    get(2'h1, gz, n);
    get(2'h0, gx, n);
    u_host.rd(2'h3, st);
    chk("x", gx, x);
    if (!ov) begin
      chk("y", gy, 32'((e >> (8 * n)) & m));
      chk("z", gz, 32'(e & m));
    end
    chk("stat", st, {7'h0, ov});
    chk("pin", ovf_n, !ov);
    $display("op done n=%0d", n);
  endtask

  initial begin
    resetn_in      = 1'b0;
    clear_n_in     = 1'b1;
    chip_enable_in = 1'b1;
    ce             = 1'b1;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_seq;
    // control first, divisor in X, never zero
    run_op(1, 2'h1, 3'b000, 32'hff, 32'hff, 32'hff);
    run_op(2, 2'h1, 3'b100, 32'hbeef, 32'h1234, 32'ha5a5);
    run_op(4, 2'h1, 3'b110, 32'h89abcdef, 32'h1234, 32'hfedcba98);
    run_op(3, 2'h2, 3'b000, 32'h3b4, 32'h0, 32'hf273);
    run_op(3, 2'h2, 3'b100, 32'h3b4, 32'h1bf, 32'h491c06);
    run_op(2, 2'h2, 3'b001, 32'h100, 32'h80, 32'hffff);
    run_op(2, 2'h2, 3'b000, 32'h10, 32'h20, 32'h0);
    finish_test;
  end

  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
endmodule
